// ==== design/vtc_cmd_defs.vh ====
// Purpose: Constants for the video timing command execution block.
// Assumes: Character clock domain only; host writes arrive as a one-cycle strobe.
// Notes: Opcodes, group codes, bit positions, increment cycles and address width live here.
// Notes on behaviour
// RULE1 - Display off with bit 2 set floats address bus and asserts blanking.
// RULE2 - Display on resumes blanking next field if bit 2, else next line.
// RULE3 - Display on returns the address bus drivers to active drive.
// RULE4 - Cursor off forces cursor output low; cursor on re-enables it.
// RULE5 - Any mix of pen, display, cursor selections in one byte works.
// RULE6 - Reset status clears each status bit whose operand bit is one.
// RULE7 - Operand bits: 0 pen, 1 ready, 2 split, 3 line zero, 4 vblank.
// RULE8 - Disable interrupts clears mask bits of the selected conditions.
// RULE9 - Enable interrupts clears selected status bits and sets their masks.
// RULE10 - Buffer access during active display waits for next horizontal blank.
// RULE11 - Buffer access in vertical retrace or display off runs at once.
// RULE12 - Increment cursor starts at once and finishes in about three clocks.
// RULE13 - Block fill blanks until vertical blank after its final write.
// RULE14 - Host issues no new block fill before that vertical blank begins.
// RULE15 - Completing any delayed command sets ready status bit and done flag.
// RULE16 - Host waits for ready before issuing commands after a delayed one.
// RULE17 - Read/write at pointer moves one byte addressed by the pointer.
// RULE18 - Read/write at cursor moves one byte addressed by the cursor.
// RULE19 - Increment cursor adds one to cursor modulo 16K.
// RULE20 - Cursor transfer with increment transfers first, then adds one.
// RULE21 - Block fill writes latch from cursor through pointer inclusive.
// RULE22 - After block fill pointer is unchanged and cursor equals pointer.
// RULE23 - Instantaneous commands act after the write and leave ready alone.
// RULE24 - Top bits 010 reset status, 100 disable, 011 enable interrupts.
// RULE25 - Delayed opcodes A4, A2, A9, AC, AA, AD, AB, BB.
// RULE26 - On/off bytes have top bits 001; bit 0 off/on; bits 4,3,1 select.
// RULE27 - Pending delayed command held with a flag cleared at completion.
`ifndef VTC_CMD_DEFS_VH
`define VTC_CMD_DEFS_VH
`define VTC_OP_RD_PTR 8'hA4
`define VTC_OP_WR_PTR 8'hA2
`define VTC_OP_INC_CUR 8'hA9
`define VTC_OP_RD_CUR 8'hAC
`define VTC_OP_WR_CUR 8'hAA
`define VTC_OP_RD_CUR_INC 8'hAD
`define VTC_OP_WR_CUR_INC 8'hAB
`define VTC_OP_FILL 8'hBB
`define VTC_GRP_ONOFF 3'h1
`define VTC_GRP_RST 3'h2
`define VTC_GRP_ENA 3'h3
`define VTC_GRP_DIS 3'h4
`define VTC_BIT_ONOFF 0
`define VTC_BIT_SEL1 1
`define VTC_BIT_NFLD 2
`define VTC_BIT_SEL3 3
`define VTC_BIT_SEL4 4
`define VTC_IS_PEN 0
`define VTC_IS_READY 1
`define VTC_IS_SPLIT 2
`define VTC_IS_LZERO 3
`define VTC_IS_VBLANK 4
`define VTC_INC_CYCLES 3
`define VTC_ADDR_W 14
`endif

// ==== design/vtc_cmd_exec.v ====
// Purpose: Command execution of a CRT video timing controller.
// Assumes: cmdWrite pulses one cycle after the host write strobe ends.
// Notes: Memory port is a single-cycle strobe; read data must stand while it is high.
// Notes: Only one delayed command is held; a second one while busy is dropped, so
// the host must wait for the done flag before it writes again.
`include "vtc_cmd_defs.vh"
`default_nettype none
module vtc_cmd_exec #(
    parameter AW = `VTC_ADDR_W
) (
    // Clock, reset, enable.
    input wire sys_clk,
    input wire reset,
    input wire clkEn,
    // Host command and latch.
    input wire cmdWrite,
    input wire [7:0] cmdByte,
    input wire latchLoad,
    input wire [7:0] latchIn,
    input wire [AW-1:0] pointerIn,
    input wire pointerLoad,
    input wire [AW-1:0] cursorIn,
    input wire cursorLoad,
    // Raster timing from the timing generator.
    input wire hBlank,
    input wire vBlank,
    input wire fieldStart,
    input wire lineStart,
    input wire rasterBlank,
    input wire rasterCursor,
    // Raw interrupt events.
    input wire [4:0] eventIn,
    // Display memory.
    input wire [7:0] memRdData,
    output reg memRd,
    output reg memWr,
    output reg [AW-1:0] memAddr,
    output reg [7:0] memWrData,
    // Display outputs.
    output reg [AW-1:0] display_address_bus,
    output reg displayAddrOe,
    output reg blankOut,
    output reg cursorOut,
    // Host status.
    output reg [7:0] latchOut,
    output reg [AW-1:0] cursorOut16,
    output reg [4:0] statusOut,
    output reg [4:0] maskOut,
    output reg command_done_flag,
    output reg interrupt_request_out,
    output reg penEnable
);
    // Sequencer states; the read capture state exists because the latch takes
    // memory data at the edge that ends the read strobe.
    localparam ST_IDLE = 3'h0;
    localparam ST_WAIT = 3'h1;
    localparam ST_XFER = 3'h2;
    localparam ST_INC = 3'h3;
    localparam ST_FILL = 3'h4;
    localparam ST_RDCAP = 3'h6;

    // Sequencer state, the held command and the host-visible address registers.
    reg [2:0] state_q;
    reg [7:0] pendCmd_q;
    reg pending_q;
    reg dispOn_q;
    reg resumeWait_q;
    reg resumeField_q;
    reg cursorEn_q;
    reg fillBlank_q;
    reg vBlankPrev_q;
    reg [AW-1:0] pointer_q;
    reg [AW-1:0] cursor_q;
    reg [7:0] latch_q;
    reg [4:0] status_q;
    reg [4:0] mask_q;
    reg incStart;
    wire incDone;
    wire grpOnOff = cmdWrite && (cmdByte[7:5] == `VTC_GRP_ONOFF);
    wire grpRst = cmdWrite && (cmdByte[7:5] == `VTC_GRP_RST); // RULE24
    wire grpEna = cmdWrite && (cmdByte[7:5] == `VTC_GRP_ENA); // RULE24
    wire grpDis = cmdWrite && (cmdByte[7:5] == `VTC_GRP_DIS); // RULE24
    // Only the eight listed opcodes start a delayed command; other bytes there do nothing.
    wire isDelayed = cmdWrite && (cmdByte == `VTC_OP_RD_PTR || cmdByte == `VTC_OP_WR_PTR ||
        cmdByte == `VTC_OP_INC_CUR || cmdByte == `VTC_OP_RD_CUR ||
        cmdByte == `VTC_OP_WR_CUR || cmdByte == `VTC_OP_RD_CUR_INC ||
        cmdByte == `VTC_OP_WR_CUR_INC || cmdByte == `VTC_OP_FILL); // RULE25
    // Immediate window: vertical retrace, horizontal blank, or display off.
    wire accessOk = vBlank || hBlank || !dispOn_q; // RULE10 RULE11
    // Opcode fields of the held command: bit 3 picks the cursor, bit 2 a read,
    // bit 0 the increment after a cursor transfer.
    wire pendUsesCursor = pendCmd_q[3];
    wire pendIsRead = pendCmd_q[2];
    wire pendIncr = pendCmd_q[0];
    wire [AW-1:0] xferAddr = pendUsesCursor ? cursor_q : pointer_q;
    reg completeNow;

    // The increment runs in its own counter so the sequencer only waits for done.
    vtc_cmd_incr #(
        .CYCLES(`VTC_INC_CYCLES)
    ) incUnit (
        .sys_clk(sys_clk),
        .reset(reset),
        .clkEn(clkEn),
        .start(incStart),
        .done(incDone)
    );

    // Display, cursor and light pen controls; one byte may change several.
    always @(posedge sys_clk) begin
        if (reset) begin
            dispOn_q <= 1'b0;
            displayAddrOe <= 1'b1;
            resumeWait_q <= 1'b0;
            resumeField_q <= 1'b0;
            cursorEn_q <= 1'b0;
            penEnable <= 1'b0;
        end else if (clkEn) begin
            if (resumeWait_q && (resumeField_q ? fieldStart : lineStart)) begin
                dispOn_q <= 1'b1; // RULE2
                resumeWait_q <= 1'b0;
            end
            if (grpOnOff) begin
                if (cmdByte[`VTC_BIT_SEL1]) begin
                    penEnable <= cmdByte[`VTC_BIT_ONOFF]; // RULE5
                end
                if (cmdByte[`VTC_BIT_SEL3]) begin // RULE26
                    // Display on drives the address bus at once and arms the resume, so a line or field is never cut short.
                    if (cmdByte[`VTC_BIT_ONOFF]) begin
                        displayAddrOe <= 1'b1; // RULE3
                        resumeWait_q <= 1'b1;
                        resumeField_q <= cmdByte[`VTC_BIT_NFLD]; // RULE2
                    end else begin
                        // Display off blanks at once; the drivers float only when asked.
                        dispOn_q <= 1'b0;
                        resumeWait_q <= 1'b0;
                        displayAddrOe <= !cmdByte[`VTC_BIT_NFLD]; // RULE1
                    end
                end
                if (cmdByte[`VTC_BIT_SEL4]) begin
                    cursorEn_q <= cmdByte[`VTC_BIT_ONOFF]; // RULE4
                end
            end
        end
    end

    // Delayed command sequencer; the pending flag drops only at completion.
    always @(posedge sys_clk) begin
        if (reset) begin
            state_q <= ST_IDLE;
            pending_q <= 1'b0;
            pendCmd_q <= 8'h00;
            pointer_q <= {AW{1'b0}};
            cursor_q <= {AW{1'b0}};
            latch_q <= 8'h00;
            memRd <= 1'b0;
            memWr <= 1'b0;
            memAddr <= {AW{1'b0}};
            memWrData <= 8'h00;
            fillBlank_q <= 1'b0;
            vBlankPrev_q <= 1'b0;
            incStart <= 1'b0;
            completeNow <= 1'b0;
        end else if (clkEn) begin
            memRd <= 1'b0;
            memWr <= 1'b0;
            incStart <= 1'b0;
            completeNow <= 1'b0;
            if (latchLoad) begin
                latch_q <= latchIn;
            end
            if (pointerLoad) begin
                pointer_q <= pointerIn;
            end
            if (cursorLoad) begin
                cursor_q <= cursorIn;
            end
            vBlankPrev_q <= vBlank;
            // Release waits for a fresh vertical blank after the last write, so a fill
            // that ends inside retrace keeps the screen blanked until the next one.
            // The sequencer is already idle then and takes further commands.
            if (fillBlank_q && state_q != ST_FILL && vBlank && !vBlankPrev_q) begin
                fillBlank_q <= 1'b0; // RULE13
            end
            case (state_q)
                ST_IDLE: begin
                    if (isDelayed && !pending_q) begin
                        pendCmd_q <= cmdByte; // RULE27
                        pending_q <= 1'b1;
                        if (cmdByte == `VTC_OP_INC_CUR) begin
                            incStart <= 1'b1; // RULE12
                            state_q <= ST_INC;
                        end else if (cmdByte == `VTC_OP_FILL) begin
                            fillBlank_q <= 1'b1; // RULE13
                            state_q <= ST_FILL;
                        end else begin
                            state_q <= ST_WAIT;
                        end
                    end
                end
                ST_WAIT: begin
                    // Address, data and strobe leave together from flip-flops.
                    if (accessOk) begin // RULE10 RULE11
                        memAddr <= xferAddr; // RULE17 RULE18
                        memWrData <= latch_q;
                        memRd <= pendIsRead;
                        memWr <= !pendIsRead;
                        state_q <= pendIsRead ? ST_RDCAP : ST_XFER;
                    end
                end
                ST_RDCAP: begin
                    // Memory data stands while the read strobe is high.
                    latch_q <= memRdData;
                    state_q <= ST_XFER;
                end
                ST_XFER: begin
                    if (pendUsesCursor && pendIncr) begin
                        cursor_q <= cursor_q + {{(AW-1){1'b0}}, 1'b1}; // RULE20
                    end
                    pending_q <= 1'b0;
                    completeNow <= 1'b1; // RULE15
                    state_q <= ST_IDLE;
                end
                ST_INC: begin
                    // The raster is ignored here; the increment never waits for blanking.
                    if (incDone) begin
                        cursor_q <= cursor_q + {{(AW-1){1'b0}}, 1'b1}; // RULE19
                        pending_q <= 1'b0;
                        completeNow <= 1'b1; // RULE15
                        state_q <= ST_IDLE;
                    end
                end
                ST_FILL: begin
                    // One write per clock; the cursor walks up to the pointer and stops on it.
                    memAddr <= cursor_q; // RULE21
                    memWrData <= latch_q;
                    memWr <= 1'b1;
                    if (cursor_q == pointer_q) begin
                        pending_q <= 1'b0; // RULE22
                        completeNow <= 1'b1; // RULE15
                        state_q <= ST_IDLE;
                    end else begin
                        cursor_q <= cursor_q + {{(AW-1){1'b0}}, 1'b1};
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // Raw events and command completion raise status bits; a clear in the same
    // cycle loses, so an event is never missed by a host that clears too late.
    wire [4:0] setBits = eventIn | ({4'h0, completeNow} << `VTC_IS_READY); // RULE7
    wire [4:0] clrBits = (grpRst || grpEna) ? cmdByte[4:0] : 5'h00; // RULE6 RULE9
    // Interrupt status, mask and the done flag.
    always @(posedge sys_clk) begin
        if (reset) begin
            status_q <= 5'h00;
            mask_q <= 5'h00;
            command_done_flag <= 1'b1;
        end else if (clkEn) begin
            status_q <= (status_q & ~clrBits) | setBits; // RULE6 RULE23
            if (grpEna) begin
                mask_q <= mask_q | cmdByte[4:0]; // RULE9
            end else if (grpDis) begin
                mask_q <= mask_q & ~cmdByte[4:0]; // RULE8
            end
            // Done drops when a delayed command is taken and rises when it completes.
            if (completeNow) begin
                command_done_flag <= 1'b1; // RULE15
            end else if (isDelayed && state_q == ST_IDLE && !pending_q) begin
                command_done_flag <= 1'b0;
            end
        end
    end

    // Registered outputs toward the display and host.
    always @(posedge sys_clk) begin
        if (reset) begin
            blankOut <= 1'b1;
            cursorOut <= 1'b0;
            display_address_bus <= {AW{1'b0}};
            latchOut <= 8'h00;
            cursorOut16 <= {AW{1'b0}};
            statusOut <= 5'h00;
            maskOut <= 5'h00;
            interrupt_request_out <= 1'b0;
        end else if (clkEn) begin
            blankOut <= !dispOn_q || fillBlank_q || rasterBlank; // RULE1 RULE13
            cursorOut <= cursorEn_q && rasterCursor; // RULE4
            display_address_bus <= memAddr;
            latchOut <= latch_q;
            cursorOut16 <= cursor_q;
            statusOut <= status_q;
            maskOut <= mask_q;
            // The request follows the held status, so it lags a status bit by one clock.
            interrupt_request_out <= |(status_q & mask_q); // RULE8 RULE9
        end
    end
endmodule
`default_nettype wire

// ==== design/vtc_cmd_incr.v ====
// Purpose: Cursor increment sequencer for the command execution block.
// Assumes: Started by a one-cycle pulse; cursor is updated by the caller.
// Notes: Spreads the increment over a fixed number of character clocks.
`default_nettype none
module vtc_cmd_incr #(
    parameter CYCLES = 3
) (
    // Clock and control.
    input wire sys_clk,
    input wire reset,
    input wire clkEn,
    // Handshake.
    input wire start,
    output reg done
);
    reg [3:0] count_q;
    // Counts down from start; done pulses on the last cycle so the
    // whole operation spans CYCLES clocks, matching the ready timing.
    always @(posedge sys_clk) begin
        if (reset) begin
            count_q <= 4'h0;
            done <= 1'b0;
        end else if (clkEn) begin
            done <= 1'b0;
            if (start) begin
                count_q <= CYCLES[3:0] - 4'h1;
            end else if (count_q != 4'h0) begin
                count_q <= count_q - 4'h1;
                if (count_q == 4'h1) begin
                    done <= 1'b1; // RULE12
                end
            end
        end
    end
endmodule
`default_nettype wire

// ==== test/tb.sv ====
// Purpose: Self-checking bench for the command execution block.
// Assumes: clkEn tied high; inputs change 1 ns after the rising edge.
// Notes: Each scenario task drives and judges its own commands.
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk, reset, clkEn, cmdWrite, latchLoad, pointerLoad, cursorLoad;
    logic hBlank, vBlank, fieldStart, lineStart, rasterBlank, rasterCursor;
    logic memRd, memWr, displayAddrOe, blankOut, cursorOut;
    logic command_done_flag, interrupt_request_out, penEnable;
    logic [7:0] cmdByte, latchIn, memRdData, memWrData, latchOut;
    logic [13:0] pointerIn, cursorIn, memAddr, display_address_bus, cursorOut16;
    logic [4:0] eventIn, statusOut, maskOut;
    int miscompares = 0;
    int compares = 0;
    int n;
    vtc_cmd_exec i_vtc_cmd_exec (
        .sys_clk(sys_clk), .reset(reset), .clkEn(clkEn), .cmdWrite(cmdWrite),
        .cmdByte(cmdByte), .latchLoad(latchLoad), .latchIn(latchIn), .pointerIn(pointerIn),
        .pointerLoad(pointerLoad), .cursorIn(cursorIn), .cursorLoad(cursorLoad),
        .hBlank(hBlank), .vBlank(vBlank), .fieldStart(fieldStart), .lineStart(lineStart),
        .rasterBlank(rasterBlank), .rasterCursor(rasterCursor), .eventIn(eventIn),
        .memRdData(memRdData), .memRd(memRd), .memWr(memWr), .memAddr(memAddr),
        .memWrData(memWrData), .display_address_bus(display_address_bus),
        .displayAddrOe(displayAddrOe), .blankOut(blankOut), .cursorOut(cursorOut),
        .latchOut(latchOut), .cursorOut16(cursorOut16), .statusOut(statusOut),
        .maskOut(maskOut), .command_done_flag(command_done_flag),
        .interrupt_request_out(interrupt_request_out), .penEnable(penEnable)
    );
    vtc_mem_model i_vtc_mem_model (
        .sys_clk(sys_clk), .memRd(memRd), .memWr(memWr), .memAddr(memAddr),
        .memWrData(memWrData), .memRdData(memRdData)
    );
    // Character clock at 25 MHz.
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    task automatic step(input int k);
        repeat (k) @(posedge sys_clk);
        #1;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Outputs are judged two edges after the byte is taken.
    task automatic cmd(input logic [7:0] b);
        cmdWrite = 1'b1;
        cmdByte = b;
        step(1);
        cmdWrite = 1'b0;
        step(2);
    endtask
    task automatic preset(input logic [13:0] p, input logic [13:0] c, input logic [7:0] l);
        {pointerIn, cursorIn, latchIn} = {p, c, l};
        {pointerLoad, cursorLoad, latchLoad} = 3'b111;
        step(1);
        {pointerLoad, cursorLoad, latchLoad} = 3'b000;
    endtask
    // The host never issues a command while a delayed one is busy.
    task automatic wait_done(output int k);
        k = 0;
        while (command_done_flag !== 1'b1 && k < 200) begin
            step(1);
            k++;
        end
        chk(16'(k < 200), 16'h0001);
        // Registered status trails the done flag by one clock.
        step(1);
    endtask
    task automatic pulse_ev(input logic [4:0] e);
        eventIn = e;
        step(1);
        eventIn = 5'h00;
        step(2);
    endtask
    task automatic t_reset;
        chk({blankOut, command_done_flag, displayAddrOe}, 3'b111);
        chk({statusOut, maskOut, interrupt_request_out}, 11'h000);
    endtask
    task automatic t_display;
        cmd(8'h2C);
        chk({displayAddrOe, blankOut}, 2'b01);
        cmd(8'h2D);
        chk({displayAddrOe, blankOut}, 2'b11);
        fieldStart = 1'b1;
        step(1);
        fieldStart = 1'b0;
        step(3);
        chk(blankOut, 1'b0);
        cmd(8'h28);
        chk({displayAddrOe, blankOut}, 2'b11);
        rasterCursor = 1'b1;
        cmd(8'h3B);
        chk({blankOut, penEnable, cursorOut}, 3'b111);
        lineStart = 1'b1;
        step(1);
        lineStart = 1'b0;
        step(3);
        chk(blankOut, 1'b0);
        cmd(8'h30);
        chk(cursorOut, 1'b0);
        cmd(8'h31);
        chk(cursorOut, 1'b1);
    endtask
    task automatic t_irq;
        pulse_ev(5'h1F);
        chk(statusOut, 5'h1F);
        cmd(8'h45);
        chk(statusOut, 5'h1A);
        cmd(8'h7F);
        chk({statusOut, maskOut}, 10'h01F);
        cmd(8'h88);
        chk(maskOut, 5'h17);
        pulse_ev(5'h08);
        step(1);
        chk({statusOut, interrupt_request_out}, 6'h10);
        pulse_ev(5'h10);
        step(1);
        chk(interrupt_request_out, 1'b1);
        cmd(8'h5F);
        cmd(8'h9F);
        chk({statusOut, maskOut, interrupt_request_out}, 11'h000);
    endtask
    task automatic t_delayed;
        i_vtc_mem_model.mem[100] = 8'hC3;
        preset(14'd100, 14'h3FFF, 8'h00);
        cmd(8'hA4);
        step(6);
        chk({latchOut, command_done_flag}, 9'h000);
        hBlank = 1'b1;
        wait_done(n);
        chk({latchOut, statusOut[1]}, 9'h187);
        hBlank = 1'b0;
        vBlank = 1'b1;
        cmd(8'hA9);
        wait_done(n);
        chk(16'(n <= 5), 16'h0001);
        chk(cursorOut16, 14'h0000);
        preset(14'd100, 14'd200, 8'h5A);
        cmd(8'hAB);
        wait_done(n);
        chk({i_vtc_mem_model.mem[200], cursorOut16}, {8'h5A, 14'd201});
        i_vtc_mem_model.mem[201] = 8'h3C;
        cmd(8'hAD);
        wait_done(n);
        chk({latchOut, cursorOut16}, {8'h3C, 14'd202});
        cmd(8'hAA);
        wait_done(n);
        chk({i_vtc_mem_model.mem[202], cursorOut16}, {8'h3C, 14'd202});
        cmd(8'hA2);
        wait_done(n);
        chk(i_vtc_mem_model.mem[100], 8'h3C);
        chk(display_address_bus, 14'd100);
        i_vtc_mem_model.mem[202] = 8'h96;
        cmd(8'hAC);
        wait_done(n);
        chk(latchOut, 8'h96);
    endtask
    task automatic t_fill;
        vBlank = 1'b0;
        i_vtc_mem_model.mem[9] = 8'h11;
        i_vtc_mem_model.mem[14] = 8'h11;
        preset(14'd13, 14'd10, 8'h77);
        cmd(8'hBB);
        step(8);
        chk(blankOut, 1'b1);
        for (int i = 9; i <= 14; i++) begin
            chk(i_vtc_mem_model.mem[i], (i == 9 || i == 14) ? 8'h11 : 8'h77);
        end
        vBlank = 1'b1;
        wait_done(n);
        step(3);
        chk({blankOut, cursorOut16}, {1'b0, 14'd13});
        i_vtc_mem_model.mem[13] = 8'hE1;
        cmd(8'hA4);
        wait_done(n);
        chk(latchOut, 8'hE1);
    endtask
    task automatic tally_and_finish;
        if (miscompares == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // Main sequence: reset for six cycles, then every scenario in turn.
    initial begin
        {reset, clkEn} = 2'b11;
        {cmdWrite, latchLoad, pointerLoad, cursorLoad, hBlank, vBlank} = 6'h00;
        {fieldStart, lineStart, rasterBlank, rasterCursor} = 4'h0;
        {cmdByte, latchIn, pointerIn, cursorIn, eventIn} = '0;
        step(6);
        reset = 1'b0;
        step(1);
        t_reset();
        t_display();
        t_irq();
        t_delayed();
        t_fill();
        tally_and_finish();
    end
    // The scenarios take well under a thousand cycles; this bound cuts a hang.
    initial begin
        #200000;
        miscompares++;
        tally_and_finish();
    end
endmodule
`default_nettype wire

// ==== test/vtc_cmd_exec_asserts.sv ====
// Purpose: Concurrent checks on the ports of the command execution block.
// Assumes: One clock, synchronous active-high reset, clkEn held high.
// Notes: Output lags of one or two cycles follow the hand-over timing.
`default_nettype none
module vtc_cmd_exec_asserts #(
    parameter AW = 14
) (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic reset,
    // Host and raster inputs.
    input wire logic cmdWrite,
    input wire logic [7:0] cmdByte,
    input wire logic hBlank,
    input wire logic vBlank,
    // Watched outputs.
    input wire logic memRd,
    input wire logic displayAddrOe,
    input wire logic blankOut,
    input wire logic cursorOut,
    input wire logic [4:0] statusOut,
    input wire logic [4:0] maskOut,
    input wire logic command_done_flag,
    input wire logic interrupt_request_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (reset);
    // A command byte is taken on any clocked strobe.
    wire logic take = cmdWrite;
    a_irq_on_enabled: assert property (|(statusOut & maskOut) |-> ##[0:1] interrupt_request_out)
        else $error("interrupt request missing for an enabled status bit");
    a_irq_quiet_mask: assert property (!(|(statusOut & maskOut))[*2] |-> !interrupt_request_out)
        else $error("interrupt request active with nothing enabled");
    a_delayed_busy: assert property (take && command_done_flag && cmdByte[7:4] == 4'hA
        |-> ##[1:2] !command_done_flag)
        else $error("done flag stayed high after a delayed command");
    a_ready_on_done: assert property ($rose(command_done_flag) |=> statusOut[1])
        else $error("done flag rose without the ready status bit");
    a_instant_keeps: assert property (take && command_done_flag && cmdByte[7:5] == 3'h1
        |=> command_done_flag[*2])
        else $error("instantaneous command disturbed the done flag");
    a_float_bus: assert property (take && cmdByte == 8'h2C |-> ##2 (!displayAddrOe && blankOut))
        else $error("display off with float did not blank and float");
    a_drive_bus: assert property (take && cmdByte[7:5] == 3'h1 && cmdByte[3] && cmdByte[0]
        |-> ##2 displayAddrOe)
        else $error("display on did not drive the address bus");
    a_cursor_low: assert property (take && cmdByte == 8'h30 |-> ##2 (!cursorOut)[*3])
        else $error("cursor output high after cursor off");
    a_mask_clear: assert property (take && cmdByte[7:5] == 3'h4
        |-> ##2 ((maskOut & $past(cmdByte, 2)) == 5'h00))
        else $error("disable left a selected mask bit set");
    a_mask_set: assert property (take && cmdByte[7:5] == 3'h3
        |-> ##2 ((maskOut & $past(cmdByte, 2)) == $past(cmdByte[4:0], 2)))
        else $error("enable did not set the selected mask bits");
    a_read_in_blank: assert property (memRd |-> (hBlank || vBlank || blankOut || $past(hBlank, 2)))
        else $error("buffer read during active display");
    // Main scenarios that the bench is expected to reach.
    c_fill: cover property (take && cmdByte == 8'hBB);
    c_done: cover property ($rose(command_done_flag));
    c_irq: cover property (interrupt_request_out);
endmodule
bind vtc_cmd_exec vtc_cmd_exec_asserts #(.AW(AW)) i_vtc_cmd_exec_asserts (
    .sys_clk(sys_clk), .reset(reset), .cmdWrite(cmdWrite), .cmdByte(cmdByte),
    .hBlank(hBlank), .vBlank(vBlank), .memRd(memRd), .displayAddrOe(displayAddrOe),
    .blankOut(blankOut), .cursorOut(cursorOut), .statusOut(statusOut), .maskOut(maskOut),
    .command_done_flag(command_done_flag), .interrupt_request_out(interrupt_request_out)
);
`default_nettype wire

// ==== test/vtc_mem_model.sv ====
// Purpose: Behavioural display buffer memory beside the command block.
// Assumes: Single-cycle strobes; read data is taken at the edge that ends memRd.
// Notes: The bench presets and inspects the array directly.
`default_nettype none
module vtc_mem_model (
    // Clock.
    input wire logic sys_clk,
    // Memory port from the block.
    input wire logic memRd,
    input wire logic memWr,
    input wire logic [13:0] memAddr,
    input wire logic [7:0] memWrData,
    // Read data back to the block.
    output logic [7:0] memRdData
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [0:16383];
    // Read data stands only while the strobe does; otherwise the inverse shows,
    // so a capture outside the strobe cycle never finds the right byte by chance.
    assign memRdData = memRd ? mem[memAddr] : ~mem[memAddr];
    // Writes land at the edge that ends the write strobe.
    always @(posedge sys_clk) begin
        if (memWr) begin
            mem[memAddr] <= memWrData;
        end
    end
endmodule
`default_nettype wire
